// >>> src/ssp_pkg.sv
// package: constants, register map and state encoding for the synchronous shift port
package ssp_pkg;
    localparam logic [4:0] ADDR_DATA    = 5'h00;
    localparam logic [4:0] ADDR_CTRL    = 5'h04;
    localparam logic [4:0] ADDR_STATUS  = 5'h08;
    localparam logic [4:0] ADDR_IRQ_EN  = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_CLR = 5'h10;
    localparam int         CTRL_REN_BIT  = 4;
    localparam int         CTRL_FAST_BIT = 5;
    localparam int         STAT_TX_BIT   = 1;
    localparam int         STAT_RX_BIT   = 0;
    localparam int         FRAME_BITS    = 8;
    localparam logic [3:0] SLOW_LEAD  = 4'h3;
    localparam logic [3:0] SLOW_LOW   = 4'h6;
    localparam logic [3:0] SLOW_HIGH  = 4'h3;
    localparam logic [3:0] FAST_LEAD  = 4'h1;
    localparam logic [3:0] FAST_LOW   = 4'h2;
    localparam logic [3:0] FAST_HIGH  = 4'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    typedef enum logic [3:0] {
        SH_IDLE = 4'b0001,
        SH_LEAD = 4'b0010,
        SH_LOW  = 4'b0100,
        SH_HIGH = 4'b1000
    } ssp_state_e;
endpackage

// >>> src/ssp_if.sv
// interface: engine control and status between register file and shift engine
`timescale 1ns/1ps
interface ssp_if;
    logic       start_tx;
    logic       start_rx;
    logic       fast;
    logic [7:0] tx_data;
    logic       busy;
    logic       tx_done;
    logic       rx_done;
    logic [7:0] rx_data;
    modport regs (output start_tx, start_rx, fast, tx_data, input busy, tx_done, rx_done, rx_data);
    modport eng  (input start_tx, start_rx, fast, tx_data, output busy, tx_done, rx_done, rx_data);
endinterface

// >>> src/ssp_engine.sv
// shift engine: timing of shift clock and data for one 8-bit frame
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module ssp_engine
    import ssp_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    ssp_if.eng        ctl,
    input  wire logic data_in_i,
    output logic      sclk_q,
    output logic      dout_q,
    output logic      doe_q
);
    ssp_state_e st_q;
    logic [3:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic       rx_q;
    logic       fast_q;
    logic [1:0] cap_q;
    logic [7:0] rx_buf_q;
    logic [3:0] lead_len;
    logic [3:0] low_len;
    logic [3:0] high_len;

    assign lead_len = fast_q ? FAST_LEAD : SLOW_LEAD;
    assign low_len  = fast_q ? FAST_LOW  : SLOW_LOW;
    assign high_len = fast_q ? FAST_HIGH : SLOW_HIGH;
    assign ctl.busy = (st_q != SH_IDLE);
    assign ctl.rx_data = rx_buf_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q        <= SH_IDLE;
            cnt_q       <= 4'h0;
            bit_q       <= 3'h0;
            sh_q        <= 8'h00;
            rx_q        <= 1'b0;
            fast_q      <= 1'b0;
            rx_buf_q    <= 8'h00;
            sclk_q      <= 1'b1;
            dout_q      <= 1'b1;
            doe_q       <= 1'b0;
            ctl.tx_done <= 1'b0;
            ctl.rx_done <= 1'b0;
        end else begin
            ctl.tx_done <= 1'b0;
            ctl.rx_done <= 1'b0;
            if (cap_q[1]) begin
                sh_q <= {data_in_i, sh_q[7:1]};
            end
            case (st_q)
                SH_IDLE: begin
                    sclk_q <= 1'b1;
                    if (ctl.start_tx) begin
                        sh_q   <= ctl.tx_data;
                        rx_q   <= 1'b0;
                        fast_q <= ctl.fast;
                        bit_q  <= 3'h0;
                        cnt_q  <= 4'h1;
                        doe_q  <= 1'b1;
                        dout_q <= ctl.tx_data[0];
                        st_q   <= SH_LEAD;
                    end else if (ctl.start_rx) begin
                        rx_q   <= 1'b1;
                        fast_q <= ctl.fast;
                        bit_q  <= 3'h0;
                        cnt_q  <= 4'h1;
                        doe_q  <= 1'b0;
                        st_q   <= SH_LEAD;
                    end
                end
                SH_LEAD: begin
                    if (cnt_q >= lead_len) begin
                        sclk_q <= 1'b0;
                        cnt_q  <= 4'h1;
                        st_q   <= SH_LOW;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                SH_LOW: begin
                    if (cnt_q >= low_len) begin
                        sclk_q <= 1'b1;
                        cnt_q  <= 4'h1;
                        st_q <= SH_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                SH_HIGH: begin
                    if (cnt_q >= high_len) begin
                        cnt_q <= 4'h1;
                        if (bit_q == 3'(FRAME_BITS - 1)) begin
                            if (cap_q == 2'h0) begin // last capture has landed
                                st_q   <= SH_IDLE;
                                doe_q  <= 1'b0;
                                dout_q <= 1'b1;
                                ctl.tx_done <= ~rx_q;
                                ctl.rx_done <= rx_q;
                                if (rx_q) begin
                                    rx_buf_q <= sh_q;
                                end
                            end
                        end else begin
                            bit_q <= bit_q + 3'h1;
                            if (!rx_q) begin
                                dout_q <= sh_q[1];
                                sh_q   <= {1'b0, sh_q[7:1]};
                            end
                            st_q <= SH_LEAD;
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: st_q <= SH_IDLE;
            endcase
        end
    end

    // capture strobe delayed by the two pin synchroniser stages, so the
    // bit taken is the pin level at the rising shift clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_q <= 2'h0;
        end else begin
            cap_q <= {cap_q[0], rx_q && (st_q == SH_LOW) && (cnt_q >= low_len)};
        end
    end
endmodule

// >>> src/ssp_top.sv
// top: avalon register file, interrupt and pin sampling of the shift port
`timescale 1ns/1ps
module ssp_top
    import ssp_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic [4:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    output logic             IRQ_O,
    input  wire logic        SDATA_I,
    output logic             SDATA_O,
    output logic             SDATA_OE_O,
    output logic             SCLK_O
);
    ssp_if bus ();
    logic [7:0] serial_control_register_q;
    logic [7:0] serial_buffer_register_q;
    logic [1:0] status_q;
    logic [1:0] irq_en_q;
    logic       ack_q;
    logic       din_meta_q;
    logic       din_q;
    logic       tx_pend_q;
    logic       acc;
    logic       wr;
    logic [1:0] clr;

    ssp_engine u_eng (
        .clk_i     (MCLK_I),
        .rst_i     (RESET_I),
        .ctl       (bus),
        .data_in_i (din_q),
        .sclk_q    (SCLK_O),
        .dout_q    (SDATA_O),
        .doe_q     (SDATA_OE_O)
    );

    assign acc = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    assign wr  = AVS_WRITE_I & ack_q; // writes land where waitrequest is low
    assign clr = (wr && AVS_ADDRESS_I == ADDR_IRQ_CLR) ? AVS_WRITEDATA_I[1:0] : 2'h0;
    assign bus.fast     = serial_control_register_q[CTRL_FAST_BIT];
    assign bus.tx_data  = serial_buffer_register_q;
    assign bus.start_tx = tx_pend_q & ~bus.busy;
    assign bus.start_rx = ~tx_pend_q & ~bus.busy
                          & serial_control_register_q[CTRL_REN_BIT]
                          & ~status_q[STAT_RX_BIT]
                          & ~bus.rx_done;

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            din_meta_q <= 1'b0;
            din_q      <= 1'b0;
        end else begin
            din_meta_q <= SDATA_I;
            din_q      <= din_meta_q;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            ack_q             <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            ack_q             <= acc;
            AVS_WAITREQUEST_O <= ~acc;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            serial_control_register_q <= CTRL_RESET;
            irq_en_q                  <= FLAGS_RESET;
        end else if (wr && AVS_ADDRESS_I == ADDR_CTRL) begin
            serial_control_register_q <= AVS_WRITEDATA_I[7:0];
        end else if (wr && AVS_ADDRESS_I == ADDR_IRQ_EN) begin
            irq_en_q <= AVS_WRITEDATA_I[1:0];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            serial_buffer_register_q <= 8'h00;
            tx_pend_q                <= 1'b0;
        end else if (wr && AVS_ADDRESS_I == ADDR_DATA) begin
            serial_buffer_register_q <= AVS_WRITEDATA_I[7:0];
            tx_pend_q                <= 1'b1;
        end else if (bus.start_tx) begin
            tx_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            status_q <= FLAGS_RESET;
        end else begin
            status_q[STAT_TX_BIT] <= bus.tx_done | (status_q[STAT_TX_BIT] & ~clr[STAT_TX_BIT]);
            status_q[STAT_RX_BIT] <= bus.rx_done | (status_q[STAT_RX_BIT] & ~clr[STAT_RX_BIT]);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(status_q & irq_en_q);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (AVS_READ_I && !ack_q) begin
            case (AVS_ADDRESS_I)
                ADDR_DATA:   AVS_READDATA_O <= {24'h000000, bus.rx_data};
                ADDR_CTRL:   AVS_READDATA_O <= {24'h000000, serial_control_register_q};
                ADDR_STATUS: AVS_READDATA_O <= {29'h0, tx_pend_q | bus.busy, status_q};
                ADDR_IRQ_EN: AVS_READDATA_O <= {30'h0, irq_en_q};
                default:     AVS_READDATA_O <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> sim/ssp_monitor.sv
// checker: bus handshake and shift clock timing of the shift port
`timescale 1ns/1ps
module ssp_monitor
    import ssp_pkg::*;
(
    input wire logic        MCLK_I,
    input wire logic        RESET_I,
    input wire logic [4:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        IRQ_O,
    input wire logic        SDATA_I,
    input wire logic        SDATA_O,
    input wire logic        SDATA_OE_O,
    input wire logic        SCLK_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    logic       fast_q;
    logic [4:0] cnt_q;
    logic [2:0] bit_q;
    // fast select as last written by software
    always_ff @(posedge MCLK_I) begin
        if (RESET_I)
            fast_q <= 1'b0;
        else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == ADDR_CTRL)
            fast_q <= AVS_WRITEDATA_I[CTRL_FAST_BIT];
    end
    // cycles since the last shift clock fall, and falls modulo one frame
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            cnt_q <= 5'h1f;
            bit_q <= 3'h0;
        end else if ($fell(SCLK_O)) begin
            cnt_q <= 5'h00;
            bit_q <= bit_q + 3'h1;
        end else if (cnt_q != 5'h1f)
            cnt_q <= cnt_q + 5'h01;
    end
    property p_take; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
    endproperty
    a_take: assert property (p_take) else $error("request not answered");
    property p_one; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_void; AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[1:0] != 2'h0
        |-> AVS_READDATA_O == 32'h0; endproperty
    a_void: assert property (p_void) else $error("unmapped read not zero");
    property p_low_fast; $fell(SCLK_O) && fast_q |-> !SCLK_O [*2] ##1 SCLK_O; endproperty
    a_low_fast: assert property (p_low_fast) else $error("fast low phase wrong");
    property p_low_slow; $fell(SCLK_O) && !fast_q |-> !SCLK_O [*6] ##1 SCLK_O; endproperty
    a_low_slow: assert property (p_low_slow) else $error("slow low phase wrong");
    property p_lead; $fell(SCLK_O) && SDATA_OE_O && !fast_q |-> $past(SDATA_O, 3) == SDATA_O;
    endproperty
    a_lead: assert property (p_lead) else $error("slow data lead wrong");
    property p_period; $fell(SCLK_O) && bit_q != 3'h0 |-> cnt_q == (fast_q ? 5'h03 : 5'h0b);
    endproperty
    a_period: assert property (p_period) else $error("bit period wrong");
    property p_oe; $changed(SDATA_OE_O) |-> SCLK_O; endproperty
    a_oe: assert property (p_oe) else $error("drive changed while clock low");
endmodule
bind ssp_top ssp_monitor u_ssp_monitor (
    .MCLK_I, .RESET_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
    .AVS_READDATA_O, .AVS_WAITREQUEST_O, .IRQ_O, .SDATA_I, .SDATA_O, .SDATA_OE_O, .SCLK_O
);

// >>> sim/ssp_peer.sv
// partner model: external shift register on the data pin and shift clock
`timescale 1ns/1ps
module ssp_peer (
    input  wire logic       sclk_i,
    input  wire logic       line_i,
    input  wire logic       dev_oe_i,
    input  wire logic [7:0] byte_i,
    output logic            drv_o,
    output logic            oe_o,
    output logic [7:0]      got_o
);
    int idx = 0;
    initial begin
        drv_o = 1'b1;
        oe_o  = 1'b0;
        got_o = 8'h00;
    end
    // next bit goes out on the falling shift clock, least significant first
    always @(negedge sclk_i) begin
        if (!dev_oe_i && idx < 8) begin
            drv_o <= byte_i[idx];
            oe_o  <= 1'b1;
            idx   <= idx + 1;
        end
    end
    // device bits taken on the rising clock; line released after the last bit
    always @(posedge sclk_i) begin
        if (dev_oe_i)
            got_o <= {line_i, got_o[7:1]};
        else if (idx == 8) begin
            oe_o <= 1'b0;
            idx  <= 0;
        end
    end
endmodule

// >>> sim/ssp_top_test.sv
// testbench: register access, transmit and receive frames of the shift port
`timescale 1ns/1ps
module ssp_top_test;
    import ssp_pkg::*;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [4:0]  addr  = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic [7:0]  got;
    logic        waitreq, irq, dout, doe, sclk, pdrv, poe;
    int          error_cnt = 0, n_checks = 0, falls = 0, f;
    wire         line = doe ? dout : (poe ? pdrv : 1'b1);
    ssp_top u_ssp_top (
        .MCLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(waitreq), .IRQ_O(irq), .SDATA_I(line), .SDATA_O(dout),
        .SDATA_OE_O(doe), .SCLK_O(sclk)
    );
    ssp_peer u_ssp_peer (.sclk_i(sclk), .line_i(line), .dev_oe_i(doe), .byte_i(8'h96),
        .drv_o(pdrv), .oe_o(poe), .got_o(got));
    initial forever #4 clk = ~clk;
    always @(negedge sclk) falls++;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0) chk(32'h1, 32'h0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, ADDR_CTRL, 32'h0);
        chk(q, {24'h0, CTRL_RESET});
        xfer(1'b0, 5'h02, 32'h0);
        chk(q, 32'h0);
        f = falls;
        repeat (40) @(posedge clk);
        chk(32'(falls), 32'(f));
        xfer(1'b1, ADDR_IRQ_EN, 32'h3);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, ADDR_CTRL, 32'(i) << CTRL_FAST_BIT);
            f = falls;
            xfer(1'b1, ADDR_DATA, (i != 0) ? 32'h3c : 32'ha5);
            wait_irq();
            chk({24'h0, got}, (i != 0) ? 32'h3c : 32'ha5);
            chk(32'(falls - f), 32'h8);
            repeat (30) @(posedge clk);
            xfer(1'b0, ADDR_STATUS, 32'h0);
            chk(q & 32'h3, 32'h2);
            xfer(1'b1, ADDR_IRQ_CLR, 32'h1 << STAT_TX_BIT);
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        xfer(1'b1, ADDR_CTRL, (32'h1 << CTRL_REN_BIT) | (32'h1 << CTRL_FAST_BIT));
        wait_irq();
        f = falls;
        xfer(1'b0, ADDR_DATA, 32'h0);
        chk(q, 32'h96);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(q & 32'h3, 32'h1);
        repeat (30) @(posedge clk);
        chk(32'(falls), 32'(f));
        xfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_REN_BIT);
        xfer(1'b1, ADDR_IRQ_CLR, 32'h1 << STAT_RX_BIT);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wait_irq();
        xfer(1'b0, ADDR_DATA, 32'h0);
        chk(q, 32'h96);
        xfer(1'b1, ADDR_CTRL, 32'h0);
        summarize();
    end
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
